//--- common/cps_pkg.sv
package cps_pkg;

  // Register offsets, byte addresses on a 32-bit word bus
  localparam logic [7:0] OFS_POWER_CONTROL = 8'h87;
  localparam logic [7:0] OFS_MEMORY_STACK_CONFIG = 8'haf;
  localparam logic [7:0] OFS_STACK_POINTER_UPPER = 8'hb7;
  localparam logic [7:0] OFS_PROCESSOR_STATUS_WORD = 8'hd0;
  // Registers with no printed offset in this block's map
  localparam logic [7:0] OFS_STACK_TOP_POINTER = 8'h81;
  localparam logic [7:0] OFS_POINTER_LOW_BYTE = 8'h82;
  localparam logic [7:0] OFS_POINTER_HIGH_BYTE = 8'h83;
  localparam logic [7:0] OFS_POINTER_PAGE_BYTE = 8'h84;

  // Reset values
  localparam logic [7:0] RST_POWER_CONTROL = 8'h00;
  localparam logic [7:0] RST_MEMORY_STACK_CONFIG = 8'h00;
  localparam logic [7:0] RST_PROCESSOR_STATUS_WORD = 8'h00;
  localparam logic [7:0] RST_STACK_TOP_POINTER = 8'h07;
  localparam logic [2:0] RST_STACK_POINTER_UPPER = 3'h0;
  localparam logic [7:0] RST_POINTER_BYTE = 8'h00;

  // Field positions
  localparam int PC_BAUD_DOUBLER = 7;
  localparam int PC_SERIAL_WAKE = 6;
  localparam int PC_IRQ0_WAKE = 5;
  localparam int PC_LATCH_STROBE_OFF = 4;
  localparam int PC_FLAG_B = 3;
  localparam int PC_FLAG_A = 2;
  localparam int PC_POWER_DOWN = 1;
  localparam logic [7:0] PC_WRITE_MASK = 8'hfe;
  localparam int CFG_EXT_STACK = 7;
  localparam int CFG_ONCHIP_EXTENDED_RAM_MAP = 0;
  localparam logic [7:0] CFG_WRITE_MASK = 8'h81;
  localparam int PSW_CARRY = 7;
  localparam int PSW_HALF_CARRY = 6;
  localparam int PSW_USER_ZERO = 5;
  localparam int PSW_BANK_HI = 4;
  localparam int PSW_BANK_LO = 3;
  localparam int PSW_SIGNED_WRAP = 2;
  localparam int PSW_USER_ONE = 1;
  localparam int PSW_PARITY = 0;

  // On-chip extended RAM window: lowest 2 kbytes
  localparam logic [23:0] ONCHIP_EXTENDED_RAM_LIMIT = 24'h000800;

  // Stack operation from the core
  typedef enum logic [1:0] {
    CPS_STK_NONE,
    CPS_STK_PUSH,
    CPS_STK_POP
  } cps_stack_op_t;

  // Flag update from the core's ALU
  typedef struct packed {
    logic carryWe;
    logic carry;
    logic halfCarryWe;
    logic halfCarry;
    logic signedWrapWe;
    logic signedWrap;
  } cps_flag_upd_t;

  // Control outputs to the rest of the chip
  typedef struct packed {
    logic baudDoubler;
    logic latchStrobeDisable;
    logic powerDown;
    logic [1:0] bank;
    logic extStackEnable;
    logic xramMapEnable;
  } cps_ctrl_t;

endpackage

//--- hdl/cps_core_sfrs.sv
`timescale 1ns/1ps
`default_nettype none
// Operation
// R1: Pointer is page, high, low bytes
// R2: Pointer increment carries into page byte
// R3: Push increments stack pointer before writing
// R4: Stack pointer resets to 07H
// R5: Upper stack bits in upper register low three
// R6: Upper register hidden while extended stack off
// R7: Extended stack rolls 00FFH to 0100H
// R8: Plain stack wraps FFH to 00H
// R9: Status bits 4,3 select register bank
// R10: Status word flag layout CY AC F0 OV P
// R11: Power bit 7 doubles baud rate
// R12: Power bit 6 lets serial irq wake
// R13: Power bit 5 lets irq0 wake
// R14: Power bit 4 disables latch strobe
// R15: Power bit 1 enters power-down
// R16: Unimplemented bits ignore writes; flags kept
// R17: Map bit set puts extended RAM low
// R18: Map bit clear sends accesses external
// R19: Configuration resets to 00H
module cps_core_sfrs
  import cps_pkg::*;
(
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst_b,
  // Wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  output logic wb_err_o,
  // Core pointer and stack operations
  input wire logic pointerIncrement,
  input wire cps_stack_op_t stackOp,
  input wire logic [7:0] stackWriteData,
  input wire cps_flag_upd_t flagUpdate,
  input wire logic [7:0] accumulator,
  // Wake sources
  input wire logic serialIrq,
  input wire logic external_irq0_pin,
  input wire logic irq0_edge_select,
  // Stack memory write to the core's RAM
  output logic stackWriteStrobe,
  output logic [10:0] stackWriteAddr,
  output logic [7:0] stackWriteValue,
  // Pointer and data-memory routing
  output logic [23:0] data_pointer,
  output logic [10:0] stackAddress,
  output logic dataToOnchipRam,
  // Control
  output cps_ctrl_t ctrl,
  output logic wakeUp
);

  logic [7:0] pointer_low_byte;
  logic [7:0] pointer_high_byte;
  logic [7:0] pointer_page_byte;
  logic [7:0] stack_top_pointer;
  logic [2:0] stack_pointer_upper;
  logic [7:0] power_control;
  logic [7:0] memory_stack_config;
  logic [7:0] processor_status_word;
  logic extended_stack_enable;
  logic onchip_extram_map_enable;
  logic busWrite;
  logic busRead;
  logic addrKnown;
  logic [7:0] wrByte;
  logic [7:0] rdByte;
  logic [10:0] stackNow;
  logic [10:0] next_stack;
  logic [23:0] next_pointer;
  logic [2:0] irq0Sync;
  logic irq0Level;
  logic irq0Prev;
  logic [2:0] serSync;
  logic serLevel;

  assign extended_stack_enable = memory_stack_config[CFG_EXT_STACK];
  assign onchip_extram_map_enable = memory_stack_config[CFG_ONCHIP_EXTENDED_RAM_MAP];
  assign wrByte = wb_dat_i[7:0];

  // Upper register counts as unmapped while the extended stack is off
  always_comb
  begin
    unique case (wb_adr_i)
      OFS_POINTER_LOW_BYTE, OFS_POINTER_HIGH_BYTE,
      OFS_POINTER_PAGE_BYTE, OFS_STACK_TOP_POINTER,
      OFS_POWER_CONTROL, OFS_MEMORY_STACK_CONFIG,
      OFS_PROCESSOR_STATUS_WORD: addrKnown = 1'b1;
      OFS_STACK_POINTER_UPPER: addrKnown = extended_stack_enable; // [R6]
      default: addrKnown = 1'b0;
    endcase
  end

  assign busWrite = wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o
    && wb_we_i && wb_sel_i[0] && addrKnown;
  assign busRead = wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o
    && !wb_we_i;

  // One wait state: ack or err one cycle after the request appears
  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      wb_ack_o <= 1'b0;
      wb_err_o <= 1'b0;
    end
    else
    begin
      wb_ack_o <= wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o
        && addrKnown;
      wb_err_o <= wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o
        && !addrKnown;
    end
  end

  always_comb
  begin
    unique case (wb_adr_i)
      OFS_POINTER_LOW_BYTE: rdByte = pointer_low_byte;
      OFS_POINTER_HIGH_BYTE: rdByte = pointer_high_byte;
      OFS_POINTER_PAGE_BYTE: rdByte = pointer_page_byte;
      OFS_STACK_TOP_POINTER: rdByte = stack_top_pointer;
      OFS_POWER_CONTROL: rdByte = power_control;
      OFS_MEMORY_STACK_CONFIG: rdByte = memory_stack_config;
      OFS_PROCESSOR_STATUS_WORD: rdByte = processor_status_word;
      OFS_STACK_POINTER_UPPER:
        rdByte = extended_stack_enable ? {5'h00, stack_pointer_upper}
                                       : 8'h00; // [R5] [R6]
      default: rdByte = 8'h00;
    endcase
  end

  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
      wb_dat_o <= 32'h00000000;
    else if (busRead)
      wb_dat_o <= {24'h000000, rdByte};
  end

  // Pointer increment runs over all 24 bits
  assign next_pointer = data_pointer + 24'h000001; // [R2]
  assign data_pointer = {pointer_page_byte, pointer_high_byte,
    pointer_low_byte}; // [R1]

  // Bus write has priority over a same-cycle increment of that byte
  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      pointer_low_byte <= RST_POINTER_BYTE;
      pointer_high_byte <= RST_POINTER_BYTE;
      pointer_page_byte <= RST_POINTER_BYTE;
    end
    else
    begin
      if (busWrite && wb_adr_i == OFS_POINTER_LOW_BYTE)
        pointer_low_byte <= wrByte; // [R1]
      else if (pointerIncrement)
        pointer_low_byte <= next_pointer[7:0];
      if (busWrite && wb_adr_i == OFS_POINTER_HIGH_BYTE)
        pointer_high_byte <= wrByte; // [R1]
      else if (pointerIncrement)
        pointer_high_byte <= next_pointer[15:8];
      if (busWrite && wb_adr_i == OFS_POINTER_PAGE_BYTE)
        pointer_page_byte <= wrByte; // [R1]
      else if (pointerIncrement)
        pointer_page_byte <= next_pointer[23:16]; // [R2]
    end
  end

  // Combined stack pointer; upper bits only count when extended
  assign stackNow = extended_stack_enable
    ? {stack_pointer_upper, stack_top_pointer}
    : {3'h0, stack_top_pointer};
  assign stackAddress = stackNow;

  always_comb
  begin
    unique case (stackOp)
      CPS_STK_PUSH: next_stack = stackNow + 11'h001; // [R7] [R8]
      CPS_STK_POP: next_stack = stackNow - 11'h001;
      default: next_stack = stackNow;
    endcase
  end

  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      stack_top_pointer <= RST_STACK_TOP_POINTER; // [R4]
      stack_pointer_upper <= RST_STACK_POINTER_UPPER;
    end
    else if (stackOp != CPS_STK_NONE)
    begin
      stack_top_pointer <= next_stack[7:0]; // [R8]
      if (extended_stack_enable)
        stack_pointer_upper <= next_stack[10:8]; // [R5] [R7]
    end
    else if (busWrite && wb_adr_i == OFS_STACK_TOP_POINTER)
      stack_top_pointer <= wrByte;
    else if (busWrite && wb_adr_i == OFS_STACK_POINTER_UPPER)
      stack_pointer_upper <= wrByte[2:0]; // [R5] [R6]
  end

  // Push writes memory at the already incremented address
  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      stackWriteStrobe <= 1'b0;
      stackWriteAddr <= 11'h000;
      stackWriteValue <= 8'h00;
    end
    else
    begin
      stackWriteStrobe <= stackOp == CPS_STK_PUSH; // [R3]
      // Plain stack must land at 00H after the wrap, not at 100H
      if (stackOp == CPS_STK_PUSH)
      begin
        stackWriteAddr <= extended_stack_enable ? next_stack
                                                : {3'h0, next_stack[7:0]}; // [R3] [R8]
        stackWriteValue <= stackWriteData;
      end
    end
  end

  // Parity always follows the accumulator and ignores writes
  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
      processor_status_word <= RST_PROCESSOR_STATUS_WORD;
    else
    begin
      if (busWrite && wb_adr_i == OFS_PROCESSOR_STATUS_WORD)
        processor_status_word[7:1] <= wrByte[7:1]; // [R10]
      else
      begin
        if (flagUpdate.carryWe)
          processor_status_word[PSW_CARRY] <= flagUpdate.carry; // [R10]
        if (flagUpdate.halfCarryWe)
          processor_status_word[PSW_HALF_CARRY] <= flagUpdate.halfCarry;
        if (flagUpdate.signedWrapWe)
          processor_status_word[PSW_SIGNED_WRAP] <= flagUpdate.signedWrap;
      end
      processor_status_word[PSW_PARITY] <= ^accumulator; // [R10]
    end
  end

  // Power-down clears itself on wake; a wake beats a same-cycle set
  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
      power_control <= RST_POWER_CONTROL;
    else
    begin
      if (busWrite && wb_adr_i == OFS_POWER_CONTROL)
        power_control <= wrByte & PC_WRITE_MASK; // [R16]
      if (wakeUp)
        power_control[PC_POWER_DOWN] <= 1'b0; // [R12] [R13]
    end
  end

  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
      memory_stack_config <= RST_MEMORY_STACK_CONFIG; // [R19]
    else if (busWrite && wb_adr_i == OFS_MEMORY_STACK_CONFIG)
      memory_stack_config <= wrByte & CFG_WRITE_MASK; // [R16]
  end

  // Pins arrive asynchronously: three stages, change when 2 and 3 agree
  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      irq0Sync <= 3'h7;
      irq0Level <= 1'b1;
      irq0Prev <= 1'b1;
      serSync <= 3'h0;
      serLevel <= 1'b0;
    end
    else
    begin
      irq0Sync <= {irq0Sync[1:0], external_irq0_pin};
      serSync <= {serSync[1:0], serialIrq};
      if (irq0Sync[1] == irq0Sync[2])
        irq0Level <= irq0Sync[2];
      if (serSync[1] == serSync[2])
        serLevel <= serSync[2];
      irq0Prev <= irq0Level;
    end
  end

  // Wake sources only act while power-down is requested
  always_comb
  begin
    wakeUp = 1'b0;
    if (power_control[PC_POWER_DOWN])
    begin
      if (power_control[PC_SERIAL_WAKE] && serLevel)
        wakeUp = 1'b1; // [R12]
      if (power_control[PC_IRQ0_WAKE])
      begin
        if (irq0_edge_select)
          wakeUp = wakeUp || (irq0Prev && !irq0Level); // [R13]
        else
          wakeUp = wakeUp || !irq0Level; // [R13]
      end
    end
  end

  assign ctrl.baudDoubler = power_control[PC_BAUD_DOUBLER]; // [R11]
  assign ctrl.latchStrobeDisable = power_control[PC_LATCH_STROBE_OFF]; // [R14]
  assign ctrl.powerDown = power_control[PC_POWER_DOWN]; // [R15]
  assign ctrl.bank = {processor_status_word[PSW_BANK_HI],
    processor_status_word[PSW_BANK_LO]}; // [R9]
  assign ctrl.extStackEnable = extended_stack_enable;
  assign ctrl.xramMapEnable = onchip_extram_map_enable;

  // Above 0007FFH accesses go off chip even with the map enabled
  assign dataToOnchipRam = onchip_extram_map_enable
    && (data_pointer < ONCHIP_EXTENDED_RAM_LIMIT); // [R17] [R18]

endmodule // cps_core_sfrs
`default_nettype wire

//--- verif/cps_core_sfrs_props.sv
`timescale 1ns/1ps
`default_nettype none
module cps_core_sfrs_props
  import cps_pkg::*;
(
  // Clock, reset and bus
  input wire logic sys_clk,
  input wire logic rst_b,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic wb_ack_o,
  input wire logic wb_err_o,
  // Core side
  input wire logic pointerIncrement,
  input wire cps_stack_op_t stackOp,
  input wire logic stackWriteStrobe,
  input wire logic [10:0] stackWriteAddr,
  input wire logic [23:0] data_pointer,
  input wire logic [10:0] stackAddress,
  input wire logic dataToOnchipRam,
  input wire cps_ctrl_t ctrl
);
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!rst_b);
  // A held request with its answer showing is not taken twice
  wire logic take = wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o;
  wire logic push = stackOp == CPS_STK_PUSH;
  sequence s_wr(a);
    take && wb_we_i && wb_sel_i[0] && wb_adr_i == a;
  endsequence
  property p_push;
    push |=> stackWriteStrobe && stackWriteAddr == stackAddress;
  endproperty
  a_push: assert property (p_push) else $error("push address");
  property p_roll;
    push && ctrl.extStackEnable && stackAddress == 11'h0ff
      |=> stackAddress == 11'h100;
  endproperty
  a_roll: assert property (p_roll) else $error("stack roll");
  property p_inc;
    pointerIncrement && !wb_cyc_i
      |=> data_pointer == $past(data_pointer) + 24'h1;
  endproperty
  a_inc: assert property (p_inc) else $error("pointer step");
  property p_bank;
    s_wr(OFS_PROCESSOR_STATUS_WORD) |=> ctrl.bank == $past(wb_dat_i[4:3]);
  endproperty
  a_bank: assert property (p_bank) else $error("bank select");
  property p_pwr;
    s_wr(OFS_POWER_CONTROL) |=> ctrl.baudDoubler == $past(wb_dat_i[7])
      && ctrl.latchStrobeDisable == $past(wb_dat_i[4]);
  endproperty
  a_pwr: assert property (p_pwr) else $error("power bits");
  property p_hide;
    take && wb_adr_i == OFS_STACK_POINTER_UPPER && !ctrl.extStackEnable
      |=> wb_err_o && !wb_ack_o;
  endproperty
  a_hide: assert property (p_hide) else $error("upper hidden");
  property p_map;
    dataToOnchipRam == (ctrl.xramMapEnable && data_pointer < ONCHIP_EXTENDED_RAM_LIMIT);
  endproperty
  a_map: assert property (p_map) else $error("ram map");
  property p_rst;
    $rose(rst_b) |-> stackAddress == 11'h007 && ctrl == '0;
  endproperty
  a_rst: assert property (p_rst) else $error("reset state");
endmodule // cps_core_sfrs_props
`default_nettype wire

//--- verif/cps_core_model.sv
`timescale 1ns/1ps
`default_nettype none
// Registered like a real core: a command acts one edge after it is set
module cps_core_model
  import cps_pkg::*;
(
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst_b,
  // Bit0 push, bit2 increment, bit3 flag write, bits 6:4 flags, 15:8 data
  input wire logic [15:0] cmd,
  // Core requests
  output logic pointerIncrement,
  output cps_stack_op_t stackOp,
  output logic [7:0] stackWriteData,
  output cps_flag_upd_t flagUpdate,
  output logic [7:0] accumulator
);
  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      pointerIncrement <= 1'b0;
      stackOp <= CPS_STK_NONE;
      stackWriteData <= 8'h00;
      flagUpdate <= '0;
      accumulator <= 8'h00;
    end
    else
    begin
      pointerIncrement <= cmd[2];
      stackOp <= cmd[0] ? CPS_STK_PUSH : CPS_STK_NONE;
      stackWriteData <= cmd[15:8];
      flagUpdate <= {cmd[3], cmd[4], cmd[3], cmd[5], cmd[3], cmd[6]};
      accumulator <= cmd[15:8];
    end
  end
endmodule // cps_core_model
`default_nettype wire

//--- verif/testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import cps_pkg::*;
  logic sys_clk = 1'b0, rst_b = 1'b0, wb_cyc_i = 1'b0, wb_stb_i = 1'b0;
  logic wb_we_i = 1'b0, serialIrq = 1'b0, irq0_edge_select = 1'b0;
  logic external_irq0_pin = 1'b1;
  logic [7:0] wb_adr_i = 8'h00;
  logic [3:0] wb_sel_i = 4'h1;
  logic [31:0] wb_dat_i = 32'h0, wb_dat_o;
  logic [15:0] cmd = 16'h0;
  logic wb_ack_o, wb_err_o, pointerIncrement, stackWriteStrobe;
  logic dataToOnchipRam, wakeUp;
  logic [7:0] stackWriteData, accumulator, stackWriteValue;
  logic [10:0] stackWriteAddr, stackAddress;
  logic [23:0] data_pointer;
  cps_stack_op_t stackOp;
  cps_flag_upd_t flagUpdate;
  cps_ctrl_t ctrl;
  int n_fail = 0, n_checks = 0, cycles = 0;
  logic [31:0] seed = 32'h1a;
  cps_core_model core (.sys_clk, .rst_b, .cmd, .pointerIncrement, .stackOp,
    .stackWriteData, .flagUpdate, .accumulator);
  cps_core_sfrs uut (.sys_clk, .rst_b, .wb_cyc_i, .wb_stb_i, .wb_we_i,
    .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .wb_err_o,
    .pointerIncrement, .stackOp, .stackWriteData, .flagUpdate, .accumulator,
    .serialIrq, .external_irq0_pin, .irq0_edge_select, .stackWriteStrobe,
    .stackWriteAddr, .stackWriteValue, .data_pointer, .stackAddress,
    .dataToOnchipRam, .ctrl, .wakeUp);
  always #2 sys_clk = ~sys_clk;
  always @(posedge sys_clk)
  begin
    cycles++;
    if (cycles == 5000)
    begin
      n_fail++;
      end_sim();
    end
  end
  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  task automatic chk(input string nm, input logic [31:0] ex, got);
    n_checks++;
    if (got !== ex)
    begin
      n_fail++;
      $display("ERROR %s expected %h seen %h", nm, ex, got);
    end
  endtask
  task automatic wb(input logic w, input logic [7:0] a, d,
    output logic [7:0] q, output logic e);
    int n;
    @(posedge sys_clk);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= w;
    wb_adr_i <= a;
    wb_dat_i <= {24'h0, d};
    n = 0;
    do
    begin
      @(posedge sys_clk);
      n++;
    end
    while (wb_ack_o !== 1'b1 && wb_err_o !== 1'b1 && n < 20);
    q = wb_dat_o[7:0];
    e = wb_err_o;
    if (n == 20)
      n_fail++;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, d);
    logic [7:0] q;
    logic e;
    wb(1'b1, a, d, q, e);
  endtask
  task automatic rd(input logic [7:0] a, ex, input logic ee);
    logic [7:0] q;
    logic e;
    wb(1'b0, a, 8'h00, q, e);
    chk("read data", {24'h0, ex}, {24'h0, q});
    chk("bus error", {31'h0, ee}, {31'h0, e});
  endtask
  task automatic op(input logic [15:0] c, input int n);
    @(posedge sys_clk);
    cmd <= c;
    repeat (n) @(posedge sys_clk);
    cmd <= 16'h0;
    repeat (3) @(posedge sys_clk);
  endtask
  task automatic wt();
    int n;
    n = 0;
    while (wakeUp !== 1'b1 && n < 20)
    begin
      @(posedge sys_clk);
      n++;
    end
    chk("wake", 32'h1, {31'h0, wakeUp});
  endtask
  task automatic end_sim();
    $display("checks %0d failures %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  initial
  begin
    logic [31:0] r;
    repeat (10) @(posedge sys_clk);
    rst_b <= 1'b1;
    rd(8'h81, 8'h07, 1'b0);
    rd(8'haf, 8'h00, 1'b0);
    rd(8'h87, 8'h00, 1'b0);
    rd(8'h84, 8'h00, 1'b0);
    rd(8'hb7, 8'h00, 1'b1);
    rd(8'h00, 8'h00, 1'b1);
    $display("reset test done");
    wr(8'h87, 8'hfd);
    rd(8'h87, 8'hfc, 1'b0);
    chk("baud", 32'h1, {31'h0, ctrl.baudDoubler});
    chk("strobe off", 32'h1, {31'h0, ctrl.latchStrobeDisable});
    wr(8'h87, 8'h42);
    chk("power down", 32'h1, {31'h0, ctrl.powerDown});
    serialIrq <= 1'b1;
    wt();
    rd(8'h87, 8'h40, 1'b0);
    serialIrq <= 1'b0;
    for (int m = 0; m < 2; m++)
    begin
      irq0_edge_select <= m[0];
      wr(8'h87, 8'h22);
      external_irq0_pin <= 1'b0;
      wt();
      external_irq0_pin <= 1'b1;
      rd(8'h87, 8'h20, 1'b0);
    end
    wr(8'h87, 8'h00);
    $display("power test done");
    wr(8'hb7, 8'h05);
    wb_sel_i <= 4'h0;
    wr(8'haf, 8'h81);
    wb_sel_i <= 4'h1;
    rd(8'haf, 8'h00, 1'b0);
    wr(8'haf, 8'hff);
    rd(8'haf, 8'h81, 1'b0);
    rd(8'hb7, 8'h00, 1'b0);
    wr(8'h81, 8'hfe);
    op(16'h0001, 2);
    chk("stack", 32'h100, {21'h0, stackAddress});
    rd(8'hb7, 8'h01, 1'b0);
    wr(8'haf, 8'h00);
    wr(8'h81, 8'hff);
    op(16'h5a01, 1);
    chk("stack wrap", 32'h0, {21'h0, stackAddress});
    chk("push addr", 32'h0, {21'h0, stackWriteAddr});
    chk("push data", 32'h5a, {24'h0, stackWriteValue});
    $display("stack test done");
    wr(8'h82, 8'hff);
    wr(8'h83, 8'hff);
    wr(8'h84, 8'h12);
    op(16'h0004, 1);
    chk("pointer", 32'h130000, {8'h0, data_pointer});
    rd(8'h84, 8'h13, 1'b0);
    wr(8'haf, 8'h01);
    wr(8'h84, 8'h00);
    wr(8'h83, 8'h07);
    chk("onchip", 32'h1, {31'h0, dataToOnchipRam});
    wr(8'haf, 8'h00);
    chk("offchip", 32'h0, {31'h0, dataToOnchipRam});
    $display("pointer test done");
    for (int i = 0; i < 4; i++)
    begin
      r = xs();
      r[4:3] = i[1:0];
      cmd <= {r[15:8], 8'h00};
      wr(8'hd0, r[7:0]);
      rd(8'hd0, {r[7:1], ^r[15:8]}, 1'b0);
      chk("bank", {30'h0, r[4:3]}, {30'h0, ctrl.bank});
    end
    wr(8'hd0, 8'h00);
    op(16'h0078, 1);
    rd(8'hd0, 8'hc4, 1'b0);
    $display("status test done");
    end_sim();
  end
endmodule // testbench
bind cps_core_sfrs cps_core_sfrs_props chk (.sys_clk, .rst_b, .wb_cyc_i,
  .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_ack_o, .wb_err_o,
  .pointerIncrement, .stackOp, .stackWriteStrobe, .stackWriteAddr,
  .data_pointer, .stackAddress, .dataToOnchipRam, .ctrl);
`default_nettype wire
